/* File: audio_codec_link_startup_bench.sv */
// Self-checking bench for the codec link start-up and status block
module audio_codec_link_startup_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic HSEL = 1'b0;
  logic HWRITE = 1'b0;
  logic [1:0] HTRANS = 2'h0;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA, rd;
  logic HREADYOUT, HRESP, BIT_CLK, SDATA_IN0, SDATA_IN1, LINK_RESET_N, SYNC, SDATA_OUT, IRQ;
  logic [1:0] rdy = 2'b10;
  logic wake = 1'b0;
  logic [31:0] pcm = 32'h0;
  logic [255:0] last_out;
  int err_count = 0;
  int n_tests = 0;
  int r;
  // Clock and the two parties; the block boots disabled until software sets the enable bit
  always #2 MCLK = ~MCLK;
  cdl_link_ctrl DUT (.MCLK(MCLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .BIT_CLK(BIT_CLK), .SDATA_IN0(SDATA_IN0),
    .SDATA_IN1(SDATA_IN1), .LINK_RESET_N(LINK_RESET_N), .SYNC(SYNC), .SDATA_OUT(SDATA_OUT),
    .IRQ(IRQ));
  cdl_codec_model codec (.link_reset_n(LINK_RESET_N), .sdata_out(SDATA_OUT), .rdy(rdy),
    .wake(wake), .pcm(pcm), .bit_clk(BIT_CLK), .sdata_in0(SDATA_IN0), .sdata_in1(SDATA_IN1),
    .last_out(last_out));
  // Comparison and verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (err_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Bounded wait for ready; a hung slave ends the run
  task automatic wait_rdy();
    for (int n = 0; n < 64; n++) begin
      @(posedge MCLK);
      if (HREADYOUT === 1'b1) return;
    end
    err_count++;
    final_report();
  endtask
  // One single word transfer; read data taken at the completing edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HADDR <= {24'h0, a};
    HTRANS <= 2'h2;
    HWRITE <= w;
    wait_rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_rdy();
    rd = HRDATA;
  endtask
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask
  // Sample field of a slot in the last whole frame sent
  function automatic logic [15:0] slot(input int s);
    return last_out[255 - (16 + 20 * (s - 1)) -: 16];
  endfunction
  // Wait for k frame starts, bounded by a few frame lengths
  task automatic frames(input int k);
    logic p;
    p = SYNC;
    for (int n = 0; n < 18000; n++) begin
      @(posedge MCLK);
      if (SYNC === 1'b1 && p === 1'b0) k--;
      if (k == 0) return;
      p = SYNC;
    end
    err_count++;
    final_report();
  endtask
  // Count bit clock rises while the frame marker keeps one level
  task automatic rises(input logic lvl, output int c);
    logic b;
    c = 0;
    b = BIT_CLK;
    for (int n = 0; n < 30000 && SYNC === lvl; n++) begin
      @(posedge MCLK);
      if (BIT_CLK === 1'b1 && b === 1'b0) c++;
      b = BIT_CLK;
    end
    // A marker stuck at one level is a hang
    if (SYNC === lvl) begin
      err_count++;
      final_report();
    end
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  // Boot state, and an unmapped word that must stay empty
  task automatic t_reset();
    check({27'h0, HRESP, LINK_RESET_N, SYNC, SDATA_OUT, IRQ}, 32'h0);
    reg_chk(8'h00, 32'hffffffff, 32'h0);
    ahb(1'b1, 8'h20, 32'hffffffff);
    reg_chk(8'h20, 32'hffffffff, 32'h0);
  endtask
  // Enable releases link reset, then frames of 16 plus 240 bit clocks
  task automatic t_start();
    repeat (260) @(posedge MCLK);
    ahb(1'b1, 8'h00, 32'h1);
    repeat (3) @(posedge MCLK);
    check({31'h0, LINK_RESET_N}, 32'h1);
    frames(1);
    rises(1'b1, r);
    check(r, 16);
    rises(1'b0, r);
    check(r, 240);
  endtask
  // Ready tags land only in their own input's flag, then gate the IRQ
  task automatic t_ready();
    reg_chk(8'h04, 32'h3, 32'h2);
    rdy <= 2'b11;
    frames(2);
    reg_chk(8'h04, 32'h3, 32'h3);
    ahb(1'b1, 8'h08, 32'h1);
    repeat (3) @(posedge MCLK);
    check({31'h0, IRQ}, 32'h1);
    rdy <= 2'b00;
    frames(2);
    ahb(1'b1, 8'h04, 32'h1);
    repeat (3) @(posedge MCLK);
    check({31'h0, IRQ}, 32'h0);
    reg_chk(8'h04, 32'h3, 32'h2);
  endtask
  // Playback slots on the wire and both recording sources
  task automatic t_pcm();
    pcm <= 32'h3c5a_a5c3;
    ahb(1'b1, 8'h10, 32'h8001_7ffe);
    ahb(1'b1, 8'h14, 32'h1234_5678);
    ahb(1'b1, 8'h18, 32'hfedc_ba98);
    ahb(1'b1, 8'h00, 32'h39);
    frames(2);
    check({slot(4), slot(3)}, 32'h8001_7ffe);
    check({slot(8), slot(7)}, 32'h1234_5678);
    check({slot(9), slot(6)}, 32'hfedc_ba98);
    reg_chk(8'h1c, 32'hffffffff, 32'h3c5a_a5c3);
    ahb(1'b1, 8'h00, 32'h79);
    frames(2);
    reg_chk(8'h1c, 32'hffffffff, 32'h0000_a5c3);
  endtask
  // A codec write, then a read, stay busy across frames, then report done
  task automatic t_acc();
    for (int k = 0; k < 2; k++) begin
      ahb(1'b1, 8'h04, 32'h4);
      ahb(1'b1, 8'h0c, (k == 0) ? 32'h0002_1234 : 32'h8002_0000);
      reg_chk(8'h04, 32'h104, 32'h100);
      for (int i = 0; i < 5 && rd[2] !== 1'b1; i++) begin
        frames(1);
        ahb(1'b0, 8'h04, 32'h0);
      end
      check(rd & 32'h104, 32'h4);
    end
    // Reply is the primary codec's slot 2 word
    reg_chk(8'h0c, 32'hffff, 32'ha5c3);
  endtask
  // Low power silences the marker; a codec wake sets its flag
  task automatic t_wake();
    pcm <= 32'h0;
    repeat (40) @(posedge MCLK);
    ahb(1'b1, 8'h00, 32'h5);
    repeat (40) @(posedge MCLK);
    check({31'h0, SYNC}, 32'h0);
    reg_chk(8'h04, 32'h8, 32'h0);
    wake <= 1'b1;
    repeat (8) @(posedge MCLK);
    reg_chk(8'h04, 32'h8, 32'h8);
    // Warm reset holds the marker high, then frames restart
    wake <= 1'b0;
    ahb(1'b1, 8'h00, 32'h3);
    repeat (8) @(posedge MCLK);
    check({31'h0, SYNC}, 32'h1);
    reg_chk(8'h04, 32'h200, 32'h200);
    repeat (300) @(posedge MCLK);
    reg_chk(8'h04, 32'h200, 32'h0);
    frames(1);
    rises(1'b1, r);
    check(r, 16);
  endtask
  // Reset, then the scenarios in turn
  initial begin
    repeat (6) @(posedge MCLK);
    RST_N <= 1'b1;
    @(posedge MCLK);
    t_reset();
    t_start();
    t_ready();
    t_pcm();
    t_acc();
    t_wake();
    final_report();
  end
endmodule

/* File: cdl_codec_model.sv */
// Behavioural model of the two codecs on the far side of the link
module cdl_codec_model (
  input wire logic link_reset_n,
  input wire logic sdata_out,
  input wire logic [1:0] rdy,
  input wire logic wake,
  input wire logic [31:0] pcm,
  output logic bit_clk,
  output logic sdata_in0,
  output logic sdata_in1,
  output logic [255:0] last_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int idx;
  logic [1:0] d;
  logic [255:0] cur;
  // Wake holds both lines high, even with the clock stopped
  assign sdata_in0 = d[0] | wake;
  assign sdata_in1 = d[1] | wake;
  // Clock starts a margin after release, off-grid from the system clock;
  // pcm left rides slots 2, 3 and 6, right slot 4, msb first;
  // a nonzero pcm also marks slot 2 valid so that register reads get a reply
  initial begin
    bit_clk = 1'b0;
    d = 2'b00;
    forever begin
      wait (link_reset_n === 1'b1);
      #201.3;
      idx = 0;
      while (link_reset_n === 1'b1) begin
        bit_clk = 1'b1;
        d = (idx == 0) ? rdy : 2'b00;
        if (idx == 2) d[0] = |pcm;
        if (idx >= 36 && idx < 52) d[0] = pcm[51 - idx];
        if (idx >= 56 && idx < 72) d[0] = pcm[71 - idx];
        if (idx >= 76 && idx < 92) d[0] = pcm[107 - idx];
        if (idx >= 116 && idx < 132) d[0] = pcm[131 - idx];
        #40;
        bit_clk = 1'b0;
        cur[255 - idx] = sdata_out;
        if (idx == 255) last_out = cur;
        #40;
        idx = (idx + 1) % 256;
      end
      d = 2'b00;
    end
  end
endmodule

/* File: cdl_defs.svh */
// Offsets, field positions, reset values and timing counts of the codec link
`ifndef CDL_DEFS_SVH
`define CDL_DEFS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CDL_OFS_CTRL 8'h00
`define CDL_OFS_STAT 8'h04
`define CDL_OFS_MASK 8'h08
`define CDL_OFS_ACC 8'h0c
`define CDL_OFS_FRONT 8'h10
`define CDL_OFS_REAR 8'h14
`define CDL_OFS_CLFE 8'h18
`define CDL_OFS_REC 8'h1c
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CDL_C_EN 0
`define CDL_C_WARM 1
`define CDL_CTRL_W 7
`define CDL_CTRL_RST 7'h00
`define CDL_STAT_W 4
`define CDL_S_BUSY 8
`define CDL_S_WARM 9
`define CDL_A_RD 31
`define CDL_A_ID_HI 25
`define CDL_A_ID_LO 24
`define CDL_A_AD_HI 22
`define CDL_A_AD_LO 16
// ----------------------------------------------------------------
// Frame shape and timing
// ----------------------------------------------------------------
`define CDL_TAG_BITS 16
`define CDL_SLOT_BITS 20
`define CDL_SMP_BITS 16
`define CDL_LAST_SLOT 12
`define CDL_CLK_MHZ 250
`define CDL_WARM_NS 1000
`define CDL_WARM_CYC ((`CDL_WARM_NS * `CDL_CLK_MHZ + 999) / 1000)
`endif

/* File: cdl_frame_cnt.sv */
// Bit, slot and offset position within one link frame
`include "cdl_defs.svh"
module cdl_frame_cnt import cdl_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic tick,
  output logic [7:0] idx,
  output logic [3:0] slot,
  output logic [4:0] off
);
  logic slot_end;
  // Tag slot is shorter than the data slots
  assign slot_end = (slot == 4'h0) ? (off == 5'(`CDL_TAG_BITS - 1))
                                   : (off == 5'(`CDL_SLOT_BITS - 1));
  // An 8-bit index wraps after 256 bits by itself
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx <= 8'h00;
      slot <= 4'h0;
      off <= 5'h00;
    end else if (!run) begin
      idx <= 8'h00;
      slot <= 4'h0;
      off <= 5'h00;
    end else if (tick) begin
      idx <= idx + 8'h01;
      off <= slot_end ? 5'h00 : off + 5'h01;
      if (slot_end) begin
        slot <= (slot == 4'(`CDL_LAST_SLOT)) ? 4'h0 : slot + 4'h1;
      end
    end
  end
endmodule

/* File: cdl_link_ctrl.sv */
// Codec link start-up, status, register access and sample slots
// ----------------------------------------------------------------
// Notes on behaviour
// RULE_01 - Enable bit drives link reset output
// RULE_02 - Enable clear after reset, link held reset
// RULE_03 - Software times at least 1 us reset
// RULE_04 - Codec keeps bit clock stopped around reset
// RULE_05 - Codec starts bit clock after reset release
// RULE_06 - Bit clock present starts sync and counting
// RULE_07 - Codec flags readiness in tag slot
// RULE_08 - Ready tag sets that input's ready flag
// RULE_09 - Ready flags polled or raise interrupt
// RULE_10 - Two independent serial data inputs
// RULE_11 - Second input reports only secondary ready
// RULE_12 - Access completion flag, polled or interrupt
// RULE_13 - 16-bit stereo playback and recording
// RULE_14 - Recording from stereo input or mic
// RULE_15 - Front 3/4, rear 7/8, center 6, lfe 9
// RULE_16 - Low power, codec wake, warm reset
// RULE_17 - Boot straps must enable the controller; the code has no straps: enable is clear after reset until software sets it
// RULE_18 - Access spans frames, then done flag
// RULE_19 - 256-bit frame, sync high 16 bits
// RULE_20 - In reset, sync, data, counter held low
// ----------------------------------------------------------------
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`include "cdl_defs.svh"
module cdl_link_ctrl import cdl_pkg::*; (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic BIT_CLK,
  input wire logic SDATA_IN0,
  input wire logic SDATA_IN1,
  output logic LINK_RESET_N,
  output logic SYNC,
  output logic SDATA_OUT,
  output logic IRQ
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cdl_ctrl_s ctrl;
  cdl_stat_s stat;
  cdl_acc_s acc;
  cdl_acc_e acc_st;
  logic [3:0] mask;
  logic [31:0] front, rear, clfe, rec;
  logic [15:0] rx_data, rx_shift, next_shift, tag;
  logic [19:0] slot_word;
  logic [8:0] warm_cnt;
  logic [7:0] ra, idx;
  logic [3:0] slot, tx_slot, set_vec, clr_vec;
  logic [4:0] off, tx_off;
  logic [2:0] s_pins;
  logic s_bclk, s_din0, s_din1, bclk_d, seen, rx_v2;
  logic b_rise, b_fall, run, samp, t_ready, sel_din, rx_bit;
  logic acc_ok, wr_pend, rd_pend, wr_ctrl, wr_stat, wr_acc;
  logic acc_go, acc_tx, any_valid, out_bit, fr_last, slot_last;
  logic rd_got, set_done, warm_go;
  logic [31:0] rd_val;
  // ----------------------------------------------------------------
  // Pin sampling and bit clock edges
  // ----------------------------------------------------------------
  cdl_sync2 #(.W(3)) u_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .d({BIT_CLK, SDATA_IN1, SDATA_IN0}),
    .q(s_pins)
  );
  assign s_bclk = s_pins[2];
  assign s_din1 = s_pins[1];
  assign s_din0 = s_pins[0];
  // Edge finder on the synchronised clock only
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      bclk_d <= 1'b0;
    end else begin
      bclk_d <= s_bclk;
    end
  end
  assign b_rise = s_bclk & ~bclk_d; // [RULE_05]
  assign b_fall = ~s_bclk & bclk_d;
  // Frame runs only when enabled, awake and not in warm reset
  assign run = ctrl.enable & ~ctrl.low_pwr & (warm_cnt == 9'h000);
  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Sizes other than a word are treated as word accesses
  assign acc_ok = HSEL & HTRANS[1] & HREADY;
  assign wr_ctrl = wr_pend & (ra == `CDL_OFS_CTRL);
  assign wr_stat = wr_pend & (ra == `CDL_OFS_STAT);
  assign wr_acc = wr_pend & (ra == `CDL_OFS_ACC);
  // Reads take one wait state so that a write just before is visible
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      ra <= 8'h00;
      HREADYOUT <= 1'b1;
      HRDATA <= 32'h0000_0000;
      HRESP <= 1'b0;
    end else begin
      wr_pend <= acc_ok & HWRITE;
      rd_pend <= acc_ok & ~HWRITE;
      HREADYOUT <= ~(acc_ok & ~HWRITE);
      HRESP <= 1'b0;
      if (acc_ok) begin
        ra <= HADDR[7:0];
      end
      if (rd_pend) begin
        HRDATA <= rd_val;
      end
    end
  end
  // Read selection, unmapped offsets read zero
  assign rd_val = (ra == `CDL_OFS_CTRL) ? {25'h0, ctrl} :
    (ra == `CDL_OFS_STAT) ? {22'h0, warm_cnt != 9'h000, acc_st != ACC_IDLE, 4'h0, stat} :
    (ra == `CDL_OFS_MASK) ? {28'h0, mask} :
    (ra == `CDL_OFS_ACC) ? {acc.rd, 5'h0, acc.id, 1'b0, acc.addr, acc.data} :
    (ra == `CDL_OFS_FRONT) ? front :
    (ra == `CDL_OFS_REAR) ? rear :
    (ra == `CDL_OFS_CLFE) ? clfe :
    (ra == `CDL_OFS_REC) ? rec : 32'h0000_0000;
  // ----------------------------------------------------------------
  // Control and sample registers
  // ----------------------------------------------------------------
  // Warm reset is a one-shot request, never stored
  assign warm_go = wr_ctrl & HWDATA[`CDL_C_WARM] & HWDATA[`CDL_C_EN]; // [RULE_16]
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl <= cdl_ctrl_s'(`CDL_CTRL_RST); // [RULE_02]
      mask <= 4'h0;
      front <= 32'h0000_0000;
      rear <= 32'h0000_0000;
      clfe <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        ctrl <= cdl_ctrl_s'(HWDATA[`CDL_CTRL_W-1:0] & ~(7'h01 << `CDL_C_WARM));
      end
      if (wr_pend && ra == `CDL_OFS_MASK) begin
        mask <= HWDATA[3:0];
      end
      if (wr_pend && ra == `CDL_OFS_FRONT) begin
        front <= HWDATA; // [RULE_13]
      end
      if (wr_pend && ra == `CDL_OFS_REAR) begin
        rear <= HWDATA;
      end
      if (wr_pend && ra == `CDL_OFS_CLFE) begin
        clfe <= HWDATA;
      end
    end
  end
  // Link reset pin mirrors the enable bit
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      LINK_RESET_N <= 1'b0;
    end else begin
      LINK_RESET_N <= ctrl.enable; // [RULE_01]
    end
  end
  // Warm reset holds sync high for at least 1 us
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      warm_cnt <= 9'h000;
    end else if (!ctrl.enable) begin
      warm_cnt <= 9'h000;
    end else if (warm_go) begin
      warm_cnt <= 9'(`CDL_WARM_CYC); // [RULE_16]
    end else if (warm_cnt != 9'h000) begin
      warm_cnt <= warm_cnt - 9'h001;
    end
  end
  // ----------------------------------------------------------------
  // Frame transmit
  // ----------------------------------------------------------------
  cdl_frame_cnt u_frame (
    .clk(MCLK),
    .rst_n(RST_N),
    .run(run),
    .tick(b_rise),
    .idx(idx),
    .slot(slot),
    .off(off)
  );
  assign acc_tx = (acc_st == ACC_SEND);
  assign any_valid = acc_tx | ctrl.front_on | ctrl.rear_on | ctrl.clfe_on;
  // Tag: frame valid, slot 1..12 valid, codec id in low bits
  assign tag = {any_valid, acc_tx, acc_tx & ~acc.rd, ctrl.front_on, ctrl.front_on,
                1'b0, ctrl.clfe_on, ctrl.rear_on, ctrl.rear_on, ctrl.clfe_on,
                3'h0, 1'b0, acc_tx ? acc.id : 2'h0}; // [RULE_15]
  // Samples occupy the upper 16 of each 20-bit slot
  assign slot_word = (slot == 4'h0) ? {tag, 4'h0} :
    (slot == 4'h1) ? {acc_tx & acc.rd, acc_tx ? acc.addr : 7'h00, 12'h000} :
    (slot == 4'h2) ? {acc_tx ? acc.data : 16'h0000, 4'h0} :
    (slot == 4'h3) ? {front[15:0], 4'h0} :
    (slot == 4'h4) ? {front[31:16], 4'h0} :
    (slot == 4'h6) ? {clfe[15:0], 4'h0} :
    (slot == 4'h7) ? {rear[15:0], 4'h0} :
    (slot == 4'h8) ? {rear[31:16], 4'h0} :
    (slot == 4'h9) ? {clfe[31:16], 4'h0} : 20'h00000; // [RULE_15]
  assign out_bit = slot_word[5'd19 - off];
  // Output changes on bit clock rises; quiet while held in reset
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      SYNC <= 1'b0;
      SDATA_OUT <= 1'b0;
      tx_slot <= 4'h0;
      tx_off <= 5'h00;
      seen <= 1'b0;
    end else if (warm_cnt != 9'h000) begin
      SYNC <= 1'b1; // [RULE_16]
      SDATA_OUT <= 1'b0;
      seen <= 1'b0;
    end else if (!run) begin
      SYNC <= 1'b0; // [RULE_20]
      SDATA_OUT <= 1'b0;
      seen <= 1'b0;
    end else if (b_rise) begin
      SYNC <= (idx < 8'(`CDL_TAG_BITS)); // [RULE_06] [RULE_19]
      SDATA_OUT <= out_bit;
      tx_slot <= slot;
      tx_off <= off;
      seen <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // Frame receive
  // ----------------------------------------------------------------
  // Inputs are read on falls, aligned with the bit sent on the rise
  assign samp = b_fall & seen & run;
  assign sel_din = (acc.id != 2'h0) ? s_din1 : s_din0; // [RULE_10]
  assign t_ready = samp & (tx_slot == 4'h0) & (tx_off == 5'h00); // [RULE_07]
  assign rx_bit = (tx_slot == 4'h2) ? sel_din : s_din0;
  assign next_shift = {rx_shift[14:0], rx_bit};
  assign slot_last = samp & (tx_off == 5'(`CDL_SMP_BITS - 1)) & (tx_slot != 4'h0);
  assign rd_got = slot_last & (tx_slot == 4'h2) & (acc_st == ACC_WAIT) & rx_v2;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_shift <= 16'h0000;
      rx_v2 <= 1'b0;
      rx_data <= 16'h0000;
      rec <= 32'h0000_0000;
    end else if (samp) begin
      rx_shift <= next_shift;
      if (tx_slot == 4'h0 && tx_off == 5'h02) begin
        rx_v2 <= sel_din;
      end
      if (rd_got) begin
        rx_data <= next_shift;
      end
      // Mic lands in the left half, right half reads zero
      if (slot_last && tx_slot == 4'h3 && !ctrl.rec_mic) begin
        rec[15:0] <= next_shift; // [RULE_14]
      end
      if (slot_last && tx_slot == 4'h4 && !ctrl.rec_mic) begin
        rec[31:16] <= next_shift; // [RULE_13]
      end
      if (slot_last && tx_slot == 4'h6 && ctrl.rec_mic) begin
        rec <= {16'h0000, next_shift}; // [RULE_14]
      end
    end
  end
  // ----------------------------------------------------------------
  // Codec register access
  // ----------------------------------------------------------------
  // A request written while one is in flight is dropped
  assign acc_go = wr_acc & (acc_st == ACC_IDLE) & ctrl.enable;
  assign fr_last = b_rise & run & (idx == 8'hff);
  assign set_done = (acc_tx & fr_last & ~acc.rd) | rd_got; // [RULE_12]
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      acc <= '0;
    end else if (acc_go) begin
      acc.rd <= HWDATA[`CDL_A_RD];
      acc.id <= HWDATA[`CDL_A_ID_HI:`CDL_A_ID_LO];
      acc.addr <= HWDATA[`CDL_A_AD_HI:`CDL_A_AD_LO];
      acc.data <= HWDATA[15:0];
    end else if (rd_got) begin
      acc.data <= next_shift;
    end
  end
  // Command goes out in a whole frame; a read waits for the reply
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_st <= ACC_IDLE;
    end else if (!ctrl.enable) begin
      acc_st <= ACC_IDLE;
    end else begin
      case (acc_st)
        ACC_IDLE: begin
          if (acc_go) begin
            acc_st <= ACC_ARM;
          end
        end
        ACC_ARM: begin
          if (fr_last) begin
            acc_st <= ACC_SEND; // [RULE_18]
          end
        end
        ACC_SEND: begin
          if (fr_last) begin
            acc_st <= acc.rd ? ACC_WAIT : ACC_IDLE; // [RULE_18]
          end
        end
        default: begin
          if (rd_got) begin
            acc_st <= ACC_IDLE;
          end
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Status flags and interrupt
  // ----------------------------------------------------------------
  assign set_vec = {ctrl.enable & ctrl.low_pwr & (s_din0 | s_din1), set_done,
                    t_ready & s_din1, t_ready & s_din0}; // [RULE_08] [RULE_11] [RULE_16]
  assign clr_vec = wr_stat ? HWDATA[`CDL_STAT_W-1:0] : 4'h0;
  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      stat <= '0;
      IRQ <= 1'b0;
    end else begin
      stat <= cdl_stat_s'((stat & ~clr_vec) | set_vec);
      IRQ <= |(stat & mask); // [RULE_09] [RULE_12]
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_frame_start;
    b_rise && run && idx == 8'h00;
  endsequence
  sequence s_tag_end;
    b_rise && run && idx == 8'(`CDL_TAG_BITS);
  endsequence
  AST_RST_EN: assert property ($rose(ctrl.enable) |=> $rose(LINK_RESET_N)) // [RULE_01]
    else $error("link reset not released after enable");
  AST_BOOT: assert property (!ctrl.enable |=> !LINK_RESET_N) // [RULE_02]
    else $error("link reset released while disabled");
  AST_SYNC_START: assert property (s_frame_start |=> SYNC && tx_slot == 4'h0) // [RULE_06]
    else $error("sync missing at frame start");
  AST_SYNC_END: assert property (s_tag_end |=> !SYNC && tx_slot == 4'h1) // [RULE_19]
    else $error("sync not dropped after tag slot");
  AST_QUIET: assert property (!LINK_RESET_N |-> !SYNC && !SDATA_OUT && idx == 8'h00) // [RULE_20]
    else $error("link active while in reset");
  AST_READY0: assert property (t_ready && s_din0 |=> stat.ready[0]) // [RULE_08]
    else $error("primary ready tag lost");
  AST_READY1: assert property (t_ready && s_din1 && !s_din0 && !stat.ready[0]
      |=> stat.ready[1] && !stat.ready[0]) // [RULE_11]
    else $error("secondary ready reported wrongly");
  AST_IRQ: assert property ((stat & mask) != 4'h0 |=> IRQ) // [RULE_09]
    else $error("interrupt not raised");
  AST_WR_DONE: assert property (acc_st == ACC_SEND && !acc.rd && fr_last && ctrl.enable
      |=> stat.done && acc_st == ACC_IDLE) // [RULE_18]
    else $error("write access did not complete");
  AST_WARM: assert property ($rose(warm_cnt != 9'h000) |=> SYNC [*8]) // [RULE_16]
    else $error("warm reset sync too short");
endmodule

/* File: cdl_pkg.sv */
// Types shared by the codec link controller
package cdl_pkg;
  // Control register fields, msb first
  typedef struct packed {
    logic rec_mic;
    logic clfe_on;
    logic rear_on;
    logic front_on;
    logic low_pwr;
    logic warm;
    logic enable;
  } cdl_ctrl_s;
  // Sticky status flags
  typedef struct packed {
    logic wake;
    logic done;
    logic [1:0] ready;
  } cdl_stat_s;
  // Codec register access request
  typedef struct packed {
    logic rd;
    logic [1:0] id;
    logic [6:0] addr;
    logic [15:0] data;
  } cdl_acc_s;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_ARM = 2'b01,
    ACC_SEND = 2'b10,
    ACC_WAIT = 2'b11
  } cdl_acc_e;
endpackage

/* File: cdl_sync2.sv */
// Two-stage synchroniser for pins from outside the system clock
module cdl_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
